// ### logic/pmcb_regs.svh
`ifndef PMCB_REGS_SVH
`define PMCB_REGS_SVH
// Overview of operation
// - operation bit 7 enables output, reset 80
// - operation bits 5:4 select margin low/high
// - response bits 7:6 shut down, follow retry
// - retry 111 restarts while fault persists
// - retry 000 never restarts; delay stays 000
// - code 7c returns input fault status byte
// - code 7d returns temperature status byte
// - code 7e returns communication status byte
// - code 88 input voltage, exponent -3
// - code 8b output voltage, exponent -12
// - code 8c output current, exponent -4
// - code 8d hot-spot temperature, exponent -2
// - code 98 returns constant revision 42
// - code 9e block returns 11 characters
// - e0 and e1 auxiliary pin config, reset 00
// - e2 power-good polarity, reset 01
// - input status bit7 overvoltage, bit4 undervoltage
// - comm status bits 7,6,5: cmd, data, pec

`define PMCB_CMD_OPERATION 8'h01
`define PMCB_CMD_VOUT_OV_RSP 8'h41
`define PMCB_CMD_IOUT_OC_RSP 8'h47
`define PMCB_CMD_OT_RSP 8'h50
`define PMCB_CMD_STAT_INPUT 8'h7c
`define PMCB_CMD_STAT_TEMP 8'h7d
`define PMCB_CMD_STAT_COMM 8'h7e
`define PMCB_CMD_VIN_MEAS 8'h88
`define PMCB_CMD_VOUT_MEAS 8'h8b
`define PMCB_CMD_IOUT_MEAS 8'h8c
`define PMCB_CMD_TEMP_MEAS 8'h8d
`define PMCB_CMD_REVISION 8'h98
`define PMCB_CMD_SERIAL 8'h9e
`define PMCB_CMD_AUX_FUNC 8'he0
`define PMCB_CMD_AUX_LOGIC 8'he1
`define PMCB_CMD_PG_POL 8'he2

`define PMCB_OPERATION_RST 8'h80
`define PMCB_VOUT_OV_RSP_VAL 8'hb8
`define PMCB_IOUT_OC_RSP_VAL 8'hf8
`define PMCB_OT_RSP_VAL 8'h80
`define PMCB_REVISION_VAL 8'h42
`define PMCB_AUX_FUNC_RST 8'h00
`define PMCB_AUX_LOGIC_RST 8'h00
`define PMCB_PG_POL_RST 8'h01
`define PMCB_OPERATION_MASK 8'hb0
`define PMCB_AUX_FUNC_MASK 8'h1f
`define PMCB_AUX_LOGIC_MASK 8'h03

`define PMCB_OP_EN_BIT 7
`define PMCB_OP_MARGIN 5:4
`define PMCB_MARGIN_BAD 2'h3
`define PMCB_RSP_CODE 7:6
`define PMCB_RSP_RETRY 5:3
`define PMCB_RSP_DELAY 2:0
`define PMCB_RETRY_ALWAYS 3'h7

`define PMCB_IN_OV_BIT 7
`define PMCB_IN_UV_BIT 4
`define PMCB_TEMP_FAULT_BIT 7
`define PMCB_TEMP_WARN_BIT 6
`define PMCB_CM_CMD_BIT 7
`define PMCB_CM_DATA_BIT 6
`define PMCB_CM_PEC_BIT 5
`define PMCB_IN_MASK 8'h90
`define PMCB_TEMP_MASK 8'hc0
`define PMCB_CM_MASK 8'he0

`define PMCB_EXP_VIN 5'h1d
`define PMCB_EXP_VOUT 5'h14
`define PMCB_EXP_IOUT 5'h1c
`define PMCB_EXP_TEMP 5'h1e

`define PMCB_SERIAL_LEN 4'hb
`endif

// ### logic/pmcb_pkg.sv
package pmcb_pkg;
   typedef struct packed {
      logic [7:0] code;
      logic write;
      logic pec_fail;
      logic [3:0] index;
      logic [15:0] wdata;
   } pmcb_req_t;

   typedef struct packed {
      logic error;
      logic [15:0] rdata;
   } pmcb_rsp_t;

   typedef struct packed {
      logic vin_ov;
      logic vin_uv;
      logic vout_ov;
      logic iout_oc;
      logic ot_fault;
      logic ot_warn;
   } pmcb_faults_t;

   typedef enum logic [1:0] {
      PMCB_ST_OFF = 2'b00,
      PMCB_ST_ON = 2'b01,
      PMCB_ST_RETRY = 2'b10,
      PMCB_ST_LATCH = 2'b11
   } pmcb_state_t;
endpackage

// ### logic/pmcb_bank.sv
`include "pmcb_regs.svh"

module pmcb_bank #(
   parameter logic [87:0] SERIAL_TEXT = 88'h30_30_30_30_30_30_30_30_30_30_30
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic lk_req_valid,
   output logic lk_req_ready,
   input wire pmcb_pkg::pmcb_req_t lk_req,
   output logic lk_rsp_valid,
   output pmcb_pkg::pmcb_rsp_t lk_rsp,
   input wire pmcb_pkg::pmcb_faults_t faults,
   input wire logic [10:0] vin_mantissa,
   input wire logic [10:0] vout_mantissa,
   input wire logic [10:0] iout_mantissa,
   input wire logic [10:0] temp_mantissa,
   output logic converter_on,
   output logic [1:0] margin_sel,
   output logic [7:0] aux_pin_function,
   output logic [7:0] aux_pin_logic,
   output logic [7:0] power_good_pol
);
   // serial text value is arbitrary; first character sits in the top byte

   // ---------------- link domain ----------------
   logic lk_rst_s1_reg;
   logic lk_rst_reg;
   logic lk_busy_reg;
   logic lk_req_tgl_reg;
   logic lk_ack_s1_reg;
   logic lk_ack_s2_reg;
   logic lk_ack_seen_reg;
   pmcb_pkg::pmcb_req_t lk_hold_reg;
   logic lk_rsp_valid_reg;
   pmcb_pkg::pmcb_rsp_t lk_rsp_reg;

   // core-domain signals read by the link side
   logic core_ack_tgl_reg;
   pmcb_pkg::pmcb_rsp_t core_rsp_reg;

   always_ff @(posedge link_clk) begin
      lk_rst_s1_reg <= rst;
      lk_rst_reg <= lk_rst_s1_reg;
   end

   always_ff @(posedge link_clk) begin
      lk_ack_s1_reg <= core_ack_tgl_reg;
      lk_ack_s2_reg <= lk_ack_s1_reg;
   end

   assign lk_req_ready = ~lk_busy_reg & ~lk_rst_reg;

   always_ff @(posedge link_clk) begin
      if (lk_rst_reg) begin
         lk_busy_reg <= 1'b0;
         lk_req_tgl_reg <= 1'b0;
         lk_ack_seen_reg <= 1'b0;
         lk_hold_reg <= '0;
         lk_rsp_valid_reg <= 1'b0;
         lk_rsp_reg <= '0;
      end else begin
         lk_rsp_valid_reg <= 1'b0;
         if (lk_req_valid && lk_req_ready) begin
            lk_hold_reg <= lk_req;
            lk_req_tgl_reg <= ~lk_req_tgl_reg;
            lk_busy_reg <= 1'b1;
         end else if (lk_busy_reg && (lk_ack_s2_reg != lk_ack_seen_reg)) begin
            lk_ack_seen_reg <= lk_ack_s2_reg;
            lk_rsp_reg <= core_rsp_reg;
            lk_rsp_valid_reg <= 1'b1;
            lk_busy_reg <= 1'b0;
         end
      end
   end

   assign lk_rsp_valid = lk_rsp_valid_reg;
   assign lk_rsp = lk_rsp_reg;

   // ---------------- core domain ----------------
   logic req_s1_reg;
   logic req_s2_reg;
   logic req_seen_reg;
   logic req_fire;

   always_ff @(posedge clk) begin
      req_s1_reg <= lk_req_tgl_reg;
      req_s2_reg <= req_s1_reg;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         req_seen_reg <= 1'b0;
      end else begin
         req_seen_reg <= req_s2_reg;
      end
   end

   // the held request is stable from the toggle until the answer returns
   assign req_fire = req_s2_reg != req_seen_reg;

   logic [10:0] vin_mant_reg;
   logic [10:0] vout_mant_reg;
   logic [10:0] iout_mant_reg;
   logic [10:0] temp_mant_reg;
   logic [7:0] operation_reg;
   logic [7:0] aux_func_reg;
   logic [7:0] aux_logic_reg;
   logic [7:0] pg_pol_reg;
   logic [7:0] stat_in_reg;
   logic [7:0] stat_temp_reg;
   logic [7:0] stat_cm_reg;

   logic [7:0] code;
   logic [15:0] wdata;
   logic is_wr;
   logic bad_cmd;
   logic bad_data;
   logic [15:0] rdata;
   logic [7:0] serial_char;
   logic [3:0] sidx;

   assign code = lk_hold_reg.code;
   assign wdata = lk_hold_reg.wdata;
   assign is_wr = lk_hold_reg.write;
   assign sidx = lk_hold_reg.index;
   assign serial_char = SERIAL_TEXT[8 * (`PMCB_SERIAL_LEN - sidx) +: 8];

   // command decode: read value, unsupported command, bad data
   always_comb begin
      rdata = 16'h0000;
      bad_cmd = 1'b0;
      bad_data = 1'b0;
      case (code)
         `PMCB_CMD_OPERATION: begin
            rdata = {8'h00, operation_reg};
            if (is_wr && ((wdata[7:0] & ~`PMCB_OPERATION_MASK) != 8'h00 ||
                          wdata[`PMCB_OP_MARGIN] == `PMCB_MARGIN_BAD)) begin
               bad_data = 1'b1;
            end
         end
         `PMCB_CMD_VOUT_OV_RSP: begin
            rdata = {8'h00, `PMCB_VOUT_OV_RSP_VAL};
            bad_cmd = is_wr;
         end
         `PMCB_CMD_IOUT_OC_RSP: begin
            rdata = {8'h00, `PMCB_IOUT_OC_RSP_VAL};
            bad_cmd = is_wr;
         end
         `PMCB_CMD_OT_RSP: begin
            rdata = {8'h00, `PMCB_OT_RSP_VAL};
            bad_cmd = is_wr;
         end
         `PMCB_CMD_STAT_INPUT: begin
            rdata = {8'h00, stat_in_reg};
         end
         `PMCB_CMD_STAT_TEMP: begin
            rdata = {8'h00, stat_temp_reg};
         end
         `PMCB_CMD_STAT_COMM: begin
            rdata = {8'h00, stat_cm_reg};
         end
         `PMCB_CMD_VIN_MEAS: begin
            rdata = {`PMCB_EXP_VIN, vin_mant_reg};
            bad_cmd = is_wr;
         end
         `PMCB_CMD_VOUT_MEAS: begin
            rdata = {`PMCB_EXP_VOUT, vout_mant_reg};
            bad_cmd = is_wr;
         end
         `PMCB_CMD_IOUT_MEAS: begin
            rdata = {`PMCB_EXP_IOUT, iout_mant_reg};
            bad_cmd = is_wr;
         end
         `PMCB_CMD_TEMP_MEAS: begin
            rdata = {`PMCB_EXP_TEMP, temp_mant_reg};
            bad_cmd = is_wr;
         end
         `PMCB_CMD_REVISION: begin
            rdata = {8'h00, `PMCB_REVISION_VAL};
            bad_cmd = is_wr;
         end
         `PMCB_CMD_SERIAL: begin
            // index 0 gives the byte count, 1..11 the characters
            if (sidx == 4'h0) begin
               rdata = {12'h000, `PMCB_SERIAL_LEN};
            end else if (sidx <= `PMCB_SERIAL_LEN) begin
               rdata = {8'h00, serial_char};
            end else begin
               bad_data = 1'b1;
            end
            bad_cmd = is_wr;
         end
         `PMCB_CMD_AUX_FUNC: begin
            rdata = {8'h00, aux_func_reg};
         end
         `PMCB_CMD_AUX_LOGIC: begin
            rdata = {8'h00, aux_logic_reg};
         end
         `PMCB_CMD_PG_POL: begin
            rdata = {8'h00, pg_pol_reg};
         end
         default: begin
            bad_cmd = 1'b1;
         end
      endcase
   end

   logic acc_ok;
   logic wr_ok;
   assign acc_ok = req_fire & ~lk_hold_reg.pec_fail & ~bad_cmd & ~bad_data;
   assign wr_ok = acc_ok & is_wr;

   // telemetry captured each cycle from the measurement logic

   always_ff @(posedge clk) begin
      if (rst) begin
         vin_mant_reg <= 11'h000;
         vout_mant_reg <= 11'h000;
         iout_mant_reg <= 11'h000;
         temp_mant_reg <= 11'h000;
      end else begin
         vin_mant_reg <= vin_mantissa;
         vout_mant_reg <= vout_mantissa;
         iout_mant_reg <= iout_mantissa;
         temp_mant_reg <= temp_mantissa;
      end
   end

   // writable configuration
   always_ff @(posedge clk) begin
      if (rst) begin
         operation_reg <= `PMCB_OPERATION_RST;
         aux_func_reg <= `PMCB_AUX_FUNC_RST;
         aux_logic_reg <= `PMCB_AUX_LOGIC_RST;
         pg_pol_reg <= `PMCB_PG_POL_RST;
      end else if (wr_ok) begin
         case (code)
            `PMCB_CMD_OPERATION: operation_reg <= wdata[7:0];
            `PMCB_CMD_AUX_FUNC: aux_func_reg <= wdata[7:0] & `PMCB_AUX_FUNC_MASK;
            `PMCB_CMD_AUX_LOGIC: aux_logic_reg <= wdata[7:0] & `PMCB_AUX_LOGIC_MASK;
            `PMCB_CMD_PG_POL: pg_pol_reg <= wdata[7:0];
            default: ;
         endcase
      end
   end

   // sticky status: set wins over a write-one-to-clear in the same cycle
   logic [7:0] in_set;
   logic [7:0] temp_set;
   logic [7:0] cm_set;
   logic [7:0] in_clr;
   logic [7:0] temp_clr;
   logic [7:0] cm_clr;

   always_comb begin
      in_set = 8'h00;
      in_set[`PMCB_IN_OV_BIT] = faults.vin_ov;
      in_set[`PMCB_IN_UV_BIT] = faults.vin_uv;
      temp_set = 8'h00;
      temp_set[`PMCB_TEMP_FAULT_BIT] = faults.ot_fault;
      temp_set[`PMCB_TEMP_WARN_BIT] = faults.ot_warn;
      cm_set = 8'h00;
      cm_set[`PMCB_CM_CMD_BIT] = req_fire & ~lk_hold_reg.pec_fail & bad_cmd;
      cm_set[`PMCB_CM_DATA_BIT] = req_fire & ~lk_hold_reg.pec_fail & ~bad_cmd & bad_data;
      cm_set[`PMCB_CM_PEC_BIT] = req_fire & lk_hold_reg.pec_fail;
   end

   assign in_clr = (wr_ok && code == `PMCB_CMD_STAT_INPUT) ? wdata[7:0] : 8'h00;
   assign temp_clr = (wr_ok && code == `PMCB_CMD_STAT_TEMP) ? wdata[7:0] : 8'h00;
   assign cm_clr = (wr_ok && code == `PMCB_CMD_STAT_COMM) ? wdata[7:0] : 8'h00;

   always_ff @(posedge clk) begin
      if (rst) begin
         stat_in_reg <= 8'h00;
         stat_temp_reg <= 8'h00;
         stat_cm_reg <= 8'h00;
      end else begin
         stat_in_reg <= ((stat_in_reg & ~in_clr) | in_set) & `PMCB_IN_MASK;
         stat_temp_reg <= ((stat_temp_reg & ~temp_clr) | temp_set) & `PMCB_TEMP_MASK;
         stat_cm_reg <= ((stat_cm_reg & ~cm_clr) | cm_set) & `PMCB_CM_MASK;
      end
   end

   // answer to the link side
   always_ff @(posedge clk) begin
      if (rst) begin
         core_ack_tgl_reg <= 1'b0;
         core_rsp_reg <= '0;
      end else if (req_fire) begin
         core_rsp_reg.error <= lk_hold_reg.pec_fail | bad_cmd | bad_data;
         core_rsp_reg.rdata <= (is_wr || !acc_ok) ? 16'h0000 : rdata;
         core_ack_tgl_reg <= ~core_ack_tgl_reg;
      end
   end

   // output shutdown and retry control
   logic ov_hit;
   logic oc_hit;
   logic ot_hit;
   logic any_hit;
   logic no_retry;
   logic out_enable;
   pmcb_pkg::pmcb_state_t state_reg;

   localparam logic [7:0] OV_RSP = `PMCB_VOUT_OV_RSP_VAL;
   localparam logic [7:0] OC_RSP = `PMCB_IOUT_OC_RSP_VAL;
   localparam logic [7:0] OT_RSP = `PMCB_OT_RSP_VAL;

   assign ov_hit = faults.vout_ov & (OV_RSP[`PMCB_RSP_CODE] != 2'h0);
   assign oc_hit = faults.iout_oc & (OC_RSP[`PMCB_RSP_CODE] != 2'h0);
   assign ot_hit = faults.ot_fault & (OT_RSP[`PMCB_RSP_CODE] != 2'h0);
   assign any_hit = ov_hit | oc_hit | ot_hit;
   // any firing fault set to never restart latches the output off
   assign no_retry =
      (ov_hit && OV_RSP[`PMCB_RSP_RETRY] != `PMCB_RETRY_ALWAYS) ||
      (oc_hit && OC_RSP[`PMCB_RSP_RETRY] != `PMCB_RETRY_ALWAYS) ||
      (ot_hit && OT_RSP[`PMCB_RSP_RETRY] != `PMCB_RETRY_ALWAYS);
   assign out_enable = operation_reg[`PMCB_OP_EN_BIT];

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= pmcb_pkg::PMCB_ST_OFF;
      end else begin
         case (state_reg)
            pmcb_pkg::PMCB_ST_OFF: begin
               if (out_enable) begin
                  state_reg <= pmcb_pkg::PMCB_ST_ON;
               end
            end
            pmcb_pkg::PMCB_ST_ON: begin
               if (!out_enable) begin
                  state_reg <= pmcb_pkg::PMCB_ST_OFF;
               end else if (any_hit && no_retry) begin
                  state_reg <= pmcb_pkg::PMCB_ST_LATCH;
               end else if (any_hit) begin
                  state_reg <= pmcb_pkg::PMCB_ST_RETRY;
               end
            end
            pmcb_pkg::PMCB_ST_RETRY: begin
               // restart with no delay; a persisting fault trips again
               if (!out_enable) begin
                  state_reg <= pmcb_pkg::PMCB_ST_OFF;
               end else begin
                  state_reg <= pmcb_pkg::PMCB_ST_ON;
               end
            end
            pmcb_pkg::PMCB_ST_LATCH: begin
               if (!out_enable) begin
                  state_reg <= pmcb_pkg::PMCB_ST_OFF;
               end
            end
            default: state_reg <= pmcb_pkg::PMCB_ST_OFF;
         endcase
      end
   end

   assign converter_on = state_reg == pmcb_pkg::PMCB_ST_ON;
   assign margin_sel = operation_reg[`PMCB_OP_MARGIN];
   assign aux_pin_function = aux_func_reg;
   assign aux_pin_logic = aux_logic_reg;
   assign power_good_pol = pg_pol_reg;
endmodule

// ### bench/pmcb_bank_props.sv
module pmcb_bank_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic lk_req_valid,
   input wire logic lk_req_ready,
   input wire pmcb_pkg::pmcb_req_t lk_req,
   input wire logic lk_rsp_valid,
   input wire pmcb_pkg::pmcb_rsp_t lk_rsp,
   input wire pmcb_pkg::pmcb_faults_t faults,
   input wire logic converter_on,
   input wire logic [1:0] margin_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   property p_ready_drop;
      @(posedge link_clk) disable iff (rst) lk_req_valid && lk_req_ready |=> !lk_req_ready;
   endproperty
   a_ready_drop: assert property (p_ready_drop) else $error("ready held after take");
   property p_answer_bound;
      @(posedge link_clk) disable iff (rst) lk_req_valid && lk_req_ready |-> ##[1:8] lk_rsp_valid;
   endproperty
   a_answer_bound: assert property (p_answer_bound) else $error("answer too late");
   property p_ready_with_rsp;
      @(posedge link_clk) disable iff (rst) lk_rsp_valid |-> lk_req_ready;
   endproperty
   a_ready_with_rsp: assert property (p_ready_with_rsp) else $error("ready low at answer");
   property p_pec_error;
      @(posedge link_clk) disable iff (rst)
         lk_req_valid && lk_req_ready && lk_req.pec_fail |-> ##[1:8] (lk_rsp_valid && lk_rsp.error);
   endproperty
   a_pec_error: assert property (p_pec_error) else $error("bad check not refused");
   property p_fault_off;
      @(posedge clk) disable iff (rst)
         converter_on && (faults.vout_ov || faults.iout_oc || faults.ot_fault) |=> !converter_on;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("no shutdown on fault");
   property p_retry;
      @(posedge clk) disable iff (rst)
         converter_on && (faults.vout_ov || faults.iout_oc) && !faults.ot_fault
         |=> !converter_on ##1 converter_on;
   endproperty
   a_retry: assert property (p_retry) else $error("no restart after fault");
   property p_latch;
      @(posedge clk) disable iff (rst) converter_on && faults.ot_fault |=> !converter_on [*8];
   endproperty
   a_latch: assert property (p_latch) else $error("restart after temperature fault");
   property p_margin_legal;
      @(posedge clk) disable iff (rst) margin_sel != 2'h3;
   endproperty
   a_margin_legal: assert property (p_margin_legal) else $error("illegal margin code");
endmodule

bind pmcb_bank pmcb_bank_props chk (.clk, .rst, .link_clk, .lk_req_valid, .lk_req_ready,
   .lk_req, .lk_rsp_valid, .lk_rsp, .faults, .converter_on, .margin_sel);

// ### bench/pmcb_host.sv
module pmcb_host (
   input wire logic link_clk,
   input wire logic lk_req_ready,
   output logic lk_req_valid,
   output pmcb_pkg::pmcb_req_t lk_req,
   input wire logic lk_rsp_valid,
   input wire pmcb_pkg::pmcb_rsp_t lk_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      lk_req_valid = 1'b0;
      lk_req = '0;
   end
   // gap idles the host for a while first, so slow and prompt hosts both occur
   task automatic xfer(input pmcb_pkg::pmcb_req_t r, input int gap,
         output pmcb_pkg::pmcb_rsp_t rsp);
      int n;
      n = 0;
      repeat (gap + 1) @(negedge link_clk);
      lk_req = r;
      lk_req_valid = 1'b1;
      while (!lk_req_ready && n < 20) begin
         @(negedge link_clk);
         n++;
      end
      @(posedge link_clk);
      @(negedge link_clk);
      lk_req_valid = 1'b0;
      // released request lines do not keep the old value
      lk_req = ~r;
      n = 0;
      while (!lk_rsp_valid && n < 12) begin
         @(negedge link_clk);
         n++;
      end
      rsp = lk_rsp_valid ? lk_rsp : 'x;
   endtask
endmodule

// ### bench/pmcb_bank_bench.sv
module pmcb_bank_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [87:0] UNIT_SERIAL_NUMBER = "ABCDEFGHIJK";
   logic clk, rst, link_clk, lk_req_valid, lk_req_ready, lk_rsp_valid, converter_on;
   pmcb_pkg::pmcb_req_t lk_req;
   pmcb_pkg::pmcb_rsp_t lk_rsp, rsp;
   pmcb_pkg::pmcb_faults_t faults;
   logic [10:0] vin_mantissa, vout_mantissa, iout_mantissa, temp_mantissa;
   logic [1:0] margin_sel;
   logic [7:0] aux_pin_function, aux_pin_logic, power_good_pol;
   int bad_count, tests_run;

   pmcb_bank #(.SERIAL_TEXT(UNIT_SERIAL_NUMBER)) dut (.clk, .rst, .link_clk, .lk_req_valid,
      .lk_req_ready,
      .lk_req, .lk_rsp_valid, .lk_rsp, .faults, .vin_mantissa, .vout_mantissa,
      .iout_mantissa, .temp_mantissa, .converter_on, .margin_sel, .aux_pin_function,
      .aux_pin_logic, .power_good_pol);
   pmcb_host host (.link_clk, .lk_req_ready, .lk_req_valid, .lk_req, .lk_rsp_valid, .lk_rsp);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #15 link_clk = ~link_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xf(input logic [7:0] c, input logic w, input logic p, input logic [3:0] i,
         input logic [15:0] d);
      host.xfer({c, w, p, i, d}, tests_run % 3, rsp);
   endtask
   task automatic rd(input logic [7:0] c, input logic [3:0] i, input logic [15:0] e);
      xf(c, 1'b0, 1'b0, i, 16'h0);
      check({rsp.error, rsp.rdata}, {1'b0, e});
   endtask
   task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic err);
      xf(c, 1'b1, 1'b0, 4'h0, {8'h00, d});
      check(rsp.error, err);
      repeat (3) @(negedge clk);
   endtask
   function automatic logic [15:0] lin(input int e, input logic [10:0] m);
      return {e[4:0], m};
   endfunction
   task automatic pulse(input pmcb_pkg::pmcb_faults_t f);
      @(negedge clk);
      faults = f;
      @(negedge clk);
      faults = '0;
      repeat (4) @(negedge clk);
   endtask

   task automatic t_defaults();
      logic [7:0] c [8] = '{8'h01, 8'h41, 8'h47, 8'h50, 8'h98, 8'he0, 8'he1, 8'he2};
      logic [7:0] v [8] = '{8'h80, 8'hb8, 8'hf8, 8'h80, 8'h42, 8'h00, 8'h00, 8'h01};
      check({converter_on, margin_sel, aux_pin_function, aux_pin_logic, power_good_pol},
         {1'b1, 2'h0, 16'h0000, 8'h01});
      for (int k = 0; k < 8; k++) rd(c[k], 4'h0, {8'h00, v[k]});
      wr(8'h47, 8'h00, 1'b1);
      wr(8'he0, 8'h12, 1'b0);
      wr(8'he1, 8'h02, 1'b0);
      wr(8'he2, 8'h00, 1'b0);
      check({aux_pin_function, aux_pin_logic, power_good_pol}, 24'h120200);
      rd(8'he0, 4'h0, 16'h0012);
      $display("defaults done");
   endtask
   task automatic t_operation();
      wr(8'h01, 8'h00, 1'b0);
      check(converter_on, 1'b0);
      wr(8'h01, 8'ha0, 1'b0);
      check({converter_on, margin_sel}, 3'h6);
      wr(8'h01, 8'h90, 1'b0);
      check({converter_on, margin_sel}, 3'h5);
      wr(8'h01, 8'hb0, 1'b1);
      wr(8'h01, 8'hc0, 1'b1);
      rd(8'h01, 4'h0, 16'h0090);
      rd(8'h7e, 4'h0, 16'h00c0);
      wr(8'h01, 8'h80, 1'b0);
      $display("operation done");
   endtask
   task automatic t_telemetry();
      @(negedge clk);
      vin_mantissa = 11'h123;
      vout_mantissa = 11'h7ff;
      iout_mantissa = 11'h001;
      temp_mantissa = 11'h400;
      repeat (3) @(negedge clk);
      rd(8'h88, 4'h0, lin(-3, 11'h123));
      rd(8'h8b, 4'h0, lin(-12, 11'h7ff));
      rd(8'h8c, 4'h0, lin(-4, 11'h001));
      rd(8'h8d, 4'h0, lin(-2, 11'h400));
      $display("telemetry done");
   endtask
   task automatic t_serial();
      rd(8'h9e, 4'h0, 16'h000b);
      for (int k = 1; k <= 11; k++)
         rd(8'h9e, k[3:0], {8'h00, UNIT_SERIAL_NUMBER[95-8*k -: 8]});
      wr(8'h7e, 8'hff, 1'b0);
      xf(8'h9e, 1'b0, 1'b0, 4'hc, 16'h0);
      check(rsp.error, 1'b1);
      rd(8'h7e, 4'h0, 16'h0040);
      $display("serial done");
   endtask
   task automatic t_comm();
      wr(8'h7e, 8'hff, 1'b0);
      xf(8'h00, 1'b0, 1'b0, 4'h0, 16'h0);
      check(rsp.error, 1'b1);
      rd(8'h7e, 4'h0, 16'h0080);
      xf(8'h98, 1'b0, 1'b1, 4'h0, 16'h0);
      check(rsp.error, 1'b1);
      rd(8'h7e, 4'h0, 16'h00a0);
      wr(8'h7e, 8'h80, 1'b0);
      rd(8'h7e, 4'h0, 16'h0020);
      $display("comm done");
   endtask
   task automatic t_status();
      pulse(6'h21);
      rd(8'h7c, 4'h0, 16'h0080);
      rd(8'h7d, 4'h0, 16'h0040);
      wr(8'h7c, 8'hff, 1'b0);
      wr(8'h7d, 8'hff, 1'b0);
      pulse(6'h10);
      rd(8'h7c, 4'h0, 16'h0010);
      wr(8'h7c, 8'h10, 1'b0);
      rd(8'h7c, 4'h0, 16'h0000);
      $display("status done");
   endtask
   task automatic t_fault();
      @(negedge clk);
      faults.vout_ov = 1'b1;
      repeat (6) @(negedge clk);
      faults = '0;
      pulse(6'h04);
      check(converter_on, 1'b1);
      pulse(6'h02);
      repeat (20) @(negedge clk);
      check(converter_on, 1'b0);
      rd(8'h7d, 4'h0, 16'h0080);
      wr(8'h01, 8'h00, 1'b0);
      wr(8'h01, 8'h80, 1'b0);
      check(converter_on, 1'b1);
      $display("fault done");
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      faults = '0;
      vin_mantissa = '0;
      vout_mantissa = '0;
      iout_mantissa = '0;
      temp_mantissa = '0;
      bad_count = 0;
      tests_run = 0;
      // long enough for the link side's reset synchroniser to see it
      repeat (30) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      t_defaults();
      t_operation();
      t_telemetry();
      t_serial();
      t_comm();
      t_status();
      t_fault();
      test_done();
   end
   initial begin
      #100000;
      bad_count++;
      test_done();
   end
endmodule
